// ===== src/mddu_pkg.sv
package mddu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes and counts
  localparam int SW = 16;
  localparam int WW = 24;
  localparam int NS = 256;
  localparam int NWS = 64;
  localparam int NB = 13;
  localparam logic [3:0] LG_N = 4'h8;
  localparam logic [3:0] LG_W = 4'h6;
  localparam logic [8:0] LAST_SMP = 9'h0FF;
  localparam logic [2:0] LAST_PASS = 3'h4;
  localparam logic [4:0] BIN_LO = 5'h0C;
  localparam logic [4:0] BIN_HI = 5'h18;
  localparam logic [4:0] VEL_HI = 5'h17;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed point: Q1.15 weights and twiddles, Q12 discriminants
  localparam int QF = 12;
  localparam int DVW = 80;
  localparam logic [6:0] DV_CNT = 7'h50;
  localparam logic signed [15:0] W_ONE = 16'sh7FFF;
  localparam logic signed [23:0] LIM_TWO = 24'sh00_2000;
  localparam logic signed [23:0] Q_MAX = 24'sh7F_FFFF;
  // Per-stage rotation exp(-j*2pi/2^s), s = 1..8
  localparam logic signed [15:0] STEP_RE [1:8] = '{
    16'sh8000, 16'sh0000, 16'sh5A82, 16'sh7642,
    16'sh7D8A, 16'sh7F62, 16'sh7FD9, 16'sh7FF6};
  localparam logic signed [15:0] STEP_IM [1:8] = '{
    16'sh0000, 16'sh8000, 16'shA57E, 16'shCF04,
    16'shE707, 16'shF374, 16'shF9B8, 16'shFCDC};

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic signed [SW-1:0] mddu_smp_t;
  typedef logic signed [WW-1:0] mddu_wk_t;
  typedef struct packed {mddu_smp_t re; mddu_smp_t im;} mddu_scplx_s;
  typedef struct packed {mddu_scplx_s ch2; mddu_scplx_s ch1;} mddu_sin_s;
  typedef struct packed {mddu_wk_t re; mddu_wk_t im;} mddu_wcplx_s;
  typedef enum logic [1:0] {
    ANG_AZM_P, ANG_AZM_N, ANG_ELV_P, ANG_ELV_N
  } mddu_ang_e;
  typedef mddu_ang_e [3:0] mddu_seq_t;
  localparam mddu_seq_t SEQ_RST =
    '{ANG_ELV_N, ANG_ELV_P, ANG_AZM_N, ANG_AZM_P};
  typedef enum logic [2:0] {
    REC_SAMPLE, REC_NARROW, REC_WIDE, REC_VEL,
    REC_DAZM, REC_DELV, REC_RAZM, REC_RELV
  } mddu_rec_e;
  typedef struct packed {
    mddu_rec_e   kind;
    logic [7:0]  idx;
    logic [1:0]  grp;
    mddu_ang_e   ang;
    mddu_wcplx_s v1;
    mddu_wcplx_s v2;
  } mddu_rec_s;
  typedef enum logic [2:0] {
    ST_COLLECT, ST_SORT, ST_LOAD, ST_FFT, ST_EMIT, ST_DSET, ST_DRUN, ST_DPUT
  } mddu_st_e;

endpackage : mddu_pkg

// ===== src/mddu_top.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RL1: Each period take 256 complex sample pairs, one per track channel.
// RL2: Split each channel into four groups of 64 consecutive samples.
// RL3: Tag each group with its group number and an angle code from the supplied order.
// RL4: After sorting, replace the stored angle order with the pending one.
// RL5: Sorting emits the samples, their group tags and the new angle order.
// RL6: Narrow filters are a weighted 256-point DFT per channel, bins 0..255.
// RL7: Wide filters are a weighted 64-point DFT per group, bins 0..63.
// RL8: Narrow bins are 29.06 Hz wide, wide bins 116.25 Hz wide.
// RL9: Both filter banks are computed by a radix-2 FFT.
// RL10: Discriminants use wide bins 12 to 24 only.
// RL11: Sum is ch1 - j*ch2, difference ch1 + j*ch2, plus channel dot product.
// RL12: Velocity term per bin pair 12..23 is sum of differences over sums.
// RL13: Angle error is twice the dot difference over summed sum powers.
// RL14: Angle error discriminants saturate to plus or minus 2.
// RL15: Angle ratio is summed difference power over summed sum power.
// RL16: Narrow and wide weights come from loadable coefficient tables.
module mddu_top
  import mddu_pkg::*;
(
  input  wire logic              i_clk,       // Processing clock
  input  wire logic              i_rst_b,     // Async reset, active low
  input  wire logic              i_smp_valid, // Sample pair offered
  input  wire mddu_sin_s         i_smp,       // Channel 1 and 2 samples
  output logic                   o_smp_ready, // Sample pair accepted
  input  wire logic              i_seq_valid, // Next angle order offered
  input  wire mddu_seq_t         i_seq,       // Angle order, next period
  input  wire logic              i_coef_we,   // Weight table write
  input  wire logic              i_coef_wide, // 1: wide table, 0: narrow
  input  wire logic [7:0]        i_coef_addr, // Weight index
  input  wire logic signed [15:0] i_coef_data, // Weight, Q1.15
  input  wire logic              i_res_ready, // Receiver takes a record
  output logic                   o_res_valid, // Record present
  output mddu_rec_s              o_res,       // Result record
  output mddu_seq_t              o_angle_seq  // Stored angle order
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  mddu_st_e          st_reg;
  logic [8:0]        idx_reg;
  logic [2:0]        pass_reg;
  logic [3:0]        stg_reg;
  logic [7:0]        p_reg;
  logic signed [15:0] twr_reg;
  logic signed [15:0] twi_reg;
  logic              smp_rdy_reg;
  mddu_seq_t         seq_reg;
  mddu_seq_t         pend_reg;
  mddu_seq_t         proc_reg;
  logic [4:0]        kb_reg;
  mddu_rec_e         job_reg;
  logic [DVW-1:0]    dv_n_reg;
  logic [63:0]       dv_d_reg;
  logic [64:0]       dv_r_reg;
  logic [6:0]        dv_cnt_reg;
  logic              dv_neg_reg;
  logic              out_v_reg;
  logic              sk_v_reg;
  mddu_rec_s         out_reg;
  mddu_rec_s         sk_reg;

  mddu_scplx_s       smp_mem [2][NS];
  mddu_wcplx_s       wk_mem [2][NS];
  mddu_wcplx_s       wd_mem [2][4][NB];
  logic signed [15:0] wn_mem [NS];
  logic signed [15:0] ww_mem [NWS];

  ////////////////////////////////////////////////////////////////////////////
  // Index arithmetic

  logic [3:0]        lg;
  logic [8:0]        nlen;
  logic [7:0]        half;
  logic [7:0]        jx;
  logic [7:0]        itop;
  logic [7:0]        ibot;
  logic [7:0]        ii;
  logic [7:0]        rev;
  logic [7:0]        src;
  logic [1:0]        gsel;
  logic signed [15:0] wt;
  logic              last_i;
  logic              last_p;
  logic [7:0]        p_nx;
  logic [7:0]        j_nx;
  logic signed [32:0] tpr;
  logic signed [32:0] tpi;
  logic              acc;

  // Narrow pass spans 4x the time of a group, hence 4x finer bins [RL8]
  assign lg     = (pass_reg == 3'h0) ? LG_N : LG_W;       // [RL6] [RL7]
  assign nlen   = 9'h001 << lg;
  assign ii     = idx_reg[7:0];
  assign last_i = (idx_reg == nlen - 9'h001);
  assign gsel   = 2'(pass_reg - 3'h1);
  // Group k covers samples 64k .. 64k+63 [RL2]
  assign src    = (pass_reg == 3'h0) ? ii : {gsel, ii[5:0]};
  assign wt     = (pass_reg == 3'h0) ? wn_mem[ii] : ww_mem[ii[5:0]]; // [RL16]
  assign rev    = 8'({<<{ii}} >> (4'h8 - lg));
  assign half   = 8'h01 << (stg_reg - 4'h1);
  assign jx     = p_reg & (half - 8'h01);
  // Top leg index 2p - j equals group*2*half + j
  assign itop   = 8'((9'(p_reg) << 1) - 9'(jx));
  assign ibot   = itop + half;
  assign last_p = ({1'b0, p_reg} == (nlen >> 1) - 9'h001);
  assign p_nx   = p_reg + 8'h01;
  assign j_nx   = p_nx & (half - 8'h01);
  // Twiddles by recursive rotation; small drift traded for no table
  assign tpr = twr_reg * STEP_RE[stg_reg] - twi_reg * STEP_IM[stg_reg];
  assign tpi = twr_reg * STEP_IM[stg_reg] + twi_reg * STEP_RE[stg_reg];
  assign acc = i_smp_valid & smp_rdy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel weighting and butterfly

  mddu_wcplx_s       ld [2];
  mddu_wcplx_s       bhi [2];
  mddu_wcplx_s       blo [2];

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    mddu_scplx_s        s;
    mddu_wcplx_s        a;
    mddu_wcplx_s        b;
    logic signed [31:0] lr;
    logic signed [31:0] li;
    logic signed [40:0] tr;
    logic signed [40:0] ti;
    assign s  = smp_mem[c][src];
    assign lr = s.re * wt;                                // [RL6] [RL7]
    assign li = s.im * wt;
    assign ld[c].re = WW'(lr >>> 15);
    assign ld[c].im = WW'(li >>> 15);
    assign a  = wk_mem[c][itop];
    assign b  = wk_mem[c][ibot];
    assign tr = b.re * twr_reg - b.im * twi_reg;          // [RL9]
    assign ti = b.re * twi_reg + b.im * twr_reg;
    assign bhi[c].re = a.re + WW'(tr >>> 15);
    assign bhi[c].im = a.im + WW'(ti >>> 15);
    assign blo[c].re = a.re - WW'(tr >>> 15);
    assign blo[c].im = a.im - WW'(ti >>> 15);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-angle sum, difference and dot terms

  function automatic logic signed [63:0] mag_apx(
    input logic signed [24:0] r,
    input logic signed [24:0] q
  );
    logic [24:0] ar;
    logic [24:0] aq;
    ar = r[24] ? 25'(-r) : 25'(r);
    aq = q[24] ? 25'(-q) : 25'(q);
    // max + min/2: cheap magnitude, within about 12 percent
    mag_apx = (ar > aq) ? 64'(ar) + 64'(aq >> 1) : 64'(aq) + 64'(ar >> 1);
  endfunction : mag_apx

  logic [3:0]         bi;
  logic [3:0]         bi1;
  logic signed [63:0] sqx [4];
  logic signed [63:0] sqc [4];
  logic signed [63:0] hd [4];
  logic signed [63:0] mk [4];
  logic signed [63:0] mk1 [4];

  assign bi  = 4'(kb_reg - BIN_LO);                        // [RL10]
  assign bi1 = (kb_reg == BIN_HI) ? bi : bi + 4'h1;

  for (genvar a = 0; a < 4; a++)
  begin : g_ang
    mddu_wcplx_s        f1;
    mddu_wcplx_s        f2;
    mddu_wcplx_s        g1;
    mddu_wcplx_s        g2;
    logic signed [24:0] xr;
    logic signed [24:0] xi;
    logic signed [24:0] cr;
    logic signed [24:0] ci;
    logic signed [24:0] yr;
    logic signed [24:0] yi;
    assign f1 = wd_mem[0][a][bi];
    assign f2 = wd_mem[1][a][bi];
    assign g1 = wd_mem[0][a][bi1];
    assign g2 = wd_mem[1][a][bi1];
    assign xr = f1.re + f2.im;                            // [RL11]
    assign xi = f1.im - f2.re;
    assign cr = f1.re - f2.im;
    assign ci = f1.im + f2.re;
    assign yr = g1.re + g2.im;
    assign yi = g1.im - g2.re;
    assign sqx[a] = xr * xr + xi * xi;
    assign sqc[a] = cr * cr + ci * ci;
    assign hd[a]  = f1.re * f2.re + f1.im * f2.im;        // [RL11]
    assign mk[a]  = mag_apx(xr, xi);
    assign mk1[a] = mag_apx(yr, yi);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ratio operands for the current job

  logic signed [63:0] num;
  logic signed [63:0] den;

  always_comb
  begin
    num = '0;
    den = '0;
    unique case (job_reg)
      REC_VEL:
      begin
        for (int a = 0; a < 4; a++)
        begin
          num = num + mk[a] - mk1[a];                     // [RL12]
          den = den + mk[a] + mk1[a];
        end
      end
      REC_DAZM:
      begin
        num = (hd[ANG_AZM_P] - hd[ANG_AZM_N]) <<< 1;      // [RL13]
        den = sqx[ANG_AZM_P] + sqx[ANG_AZM_N];
      end
      REC_DELV:
      begin
        num = (hd[ANG_ELV_P] - hd[ANG_ELV_N]) <<< 1;      // [RL13]
        den = sqx[ANG_ELV_P] + sqx[ANG_ELV_N];
      end
      REC_RAZM:
      begin
        num = sqc[ANG_AZM_P] + sqc[ANG_AZM_N];            // [RL15]
        den = sqx[ANG_AZM_P] + sqx[ANG_AZM_N];
      end
      REC_RELV:
      begin
        num = sqc[ANG_ELV_P] + sqc[ANG_ELV_N];            // [RL15]
        den = sqx[ANG_ELV_P] + sqx[ANG_ELV_N];
      end
      default:
      begin
        num = '0;
        den = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quotient finishing

  logic              ovf;
  logic signed [23:0] qmag;
  logic signed [23:0] qlim;
  logic signed [23:0] dres;

  assign ovf  = |dv_n_reg[DVW-1:23];
  assign qmag = ovf ? Q_MAX : {1'b0, dv_n_reg[22:0]};
  assign qlim = ((job_reg == REC_DAZM || job_reg == REC_DELV)
                 && qmag > LIM_TWO) ? LIM_TWO : qmag;    // [RL14]
  assign dres = dv_neg_reg ? -qlim : qlim;

  ////////////////////////////////////////////////////////////////////////////
  // Record to emit

  mddu_rec_s         rec;
  logic              emit;
  logic              push;

  always_comb
  begin
    emit = 1'b0;
    rec  = '0;
    unique case (st_reg)
      ST_SORT:
      begin
        emit        = 1'b1;                               // [RL5]
        rec.kind    = REC_SAMPLE;
        rec.idx     = ii;
        rec.grp     = ii[7:6];                            // [RL2]
        rec.ang     = seq_reg[ii[7:6]];                   // [RL3]
        rec.v1.re   = WW'(smp_mem[0][ii].re);
        rec.v1.im   = WW'(smp_mem[0][ii].im);
        rec.v2.re   = WW'(smp_mem[1][ii].re);
        rec.v2.im   = WW'(smp_mem[1][ii].im);
      end
      ST_EMIT:
      begin
        emit        = 1'b1;
        rec.kind    = (pass_reg == 3'h0) ? REC_NARROW : REC_WIDE;
        rec.idx     = ii;
        rec.grp     = (pass_reg == 3'h0) ? 2'h0 : gsel;
        rec.ang     = (pass_reg == 3'h0) ? ANG_AZM_P : proc_reg[gsel];
        rec.v1      = wk_mem[0][ii];
        rec.v2      = wk_mem[1][ii];
      end
      ST_DPUT:
      begin
        emit        = 1'b1;
        rec.kind    = job_reg;
        rec.idx     = 8'(kb_reg);
        rec.v1.re   = dres;
      end
      default:
      begin
        emit = 1'b0;
      end
    endcase
  end

  assign push = emit & ~sk_v_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_reg      <= ST_COLLECT;
      idx_reg     <= '0;
      pass_reg    <= '0;
      stg_reg     <= 4'h1;
      p_reg       <= '0;
      twr_reg     <= W_ONE;
      twi_reg     <= '0;
      smp_rdy_reg <= 1'b1;
      seq_reg     <= SEQ_RST;
      proc_reg    <= SEQ_RST;
      kb_reg      <= BIN_LO;
      job_reg     <= REC_VEL;
    end
    else
    begin
      unique case (st_reg)
        ST_COLLECT:
        begin
          if (acc)
          begin
            idx_reg <= idx_reg + 9'h001;
            if (idx_reg == LAST_SMP)                      // [RL1]
            begin
              idx_reg     <= '0;
              smp_rdy_reg <= 1'b0;
              st_reg      <= ST_SORT;
            end
          end
        end
        ST_SORT:
        begin
          if (push)
          begin
            idx_reg <= idx_reg + 9'h001;
            if (idx_reg == LAST_SMP)
            begin
              idx_reg  <= '0;
              proc_reg <= seq_reg;
              seq_reg  <= pend_reg;                       // [RL4]
              pass_reg <= '0;
              st_reg   <= ST_LOAD;
            end
          end
        end
        ST_LOAD:
        begin
          idx_reg <= idx_reg + 9'h001;
          if (last_i)
          begin
            idx_reg <= '0;
            stg_reg <= 4'h1;
            p_reg   <= '0;
            twr_reg <= W_ONE;
            twi_reg <= '0;
            st_reg  <= ST_FFT;
          end
        end
        ST_FFT:
        begin
          p_reg   <= p_nx;
          twr_reg <= (j_nx == 8'h00) ? W_ONE : 16'(tpr >>> 15); // [RL9]
          twi_reg <= (j_nx == 8'h00) ? 16'sh0000 : 16'(tpi >>> 15);
          if (last_p)
          begin
            p_reg   <= '0;
            twr_reg <= W_ONE;
            twi_reg <= '0;
            stg_reg <= stg_reg + 4'h1;
            if (stg_reg == lg)
            begin
              st_reg <= ST_EMIT;
            end
          end
        end
        ST_EMIT:
        begin
          if (push)
          begin
            idx_reg <= idx_reg + 9'h001;
            if (last_i)
            begin
              idx_reg <= '0;
              if (pass_reg == LAST_PASS)
              begin
                kb_reg  <= BIN_LO;                        // [RL10]
                job_reg <= REC_VEL;
                st_reg  <= ST_DSET;
              end
              else
              begin
                pass_reg <= pass_reg + 3'h1;
                st_reg   <= ST_LOAD;
              end
            end
          end
        end
        ST_DSET:
        begin
          st_reg <= ST_DRUN;
        end
        ST_DRUN:
        begin
          if (dv_cnt_reg == 7'h01)
          begin
            st_reg <= ST_DPUT;
          end
        end
        ST_DPUT:
        begin
          if (push)
          begin
            st_reg <= ST_DSET;
            unique case (job_reg)
              REC_VEL:  job_reg <= REC_DAZM;
              REC_DAZM: job_reg <= REC_DELV;
              REC_DELV: job_reg <= REC_RAZM;
              REC_RAZM: job_reg <= REC_RELV;
              default:
              begin
                if (kb_reg == BIN_HI)
                begin
                  smp_rdy_reg <= 1'b1;
                  st_reg      <= ST_COLLECT;
                end
                kb_reg  <= kb_reg + 5'h01;
                // Last bin has no upper neighbour [RL12]
                job_reg <= (kb_reg == VEL_HI) ? REC_DAZM : REC_VEL;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Pending order from the data processor [RL3]
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pend_reg <= SEQ_RST;
    else if (i_seq_valid)
      pend_reg <= i_seq;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restoring divider, Q12 result

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      dv_n_reg   <= '0;
      dv_d_reg   <= '0;
      dv_r_reg   <= '0;
      dv_cnt_reg <= '0;
      dv_neg_reg <= 1'b0;
    end
    else if (st_reg == ST_DSET)
    begin
      dv_n_reg   <= DVW'(num[63] ? -num : num) << QF;
      dv_d_reg   <= den;
      dv_r_reg   <= '0;
      dv_cnt_reg <= DV_CNT;
      dv_neg_reg <= num[63];
    end
    else if (st_reg == ST_DRUN)
    begin
      dv_cnt_reg <= dv_cnt_reg - 7'h01;
      // Zero denominator yields all ones, saturated downstream
      if ({dv_r_reg[63:0], dv_n_reg[DVW-1]} >= {1'b0, dv_d_reg})
      begin
        dv_r_reg <= {dv_r_reg[63:0], dv_n_reg[DVW-1]} - {1'b0, dv_d_reg};
        dv_n_reg <= {dv_n_reg[DVW-2:0], 1'b1};
      end
      else
      begin
        dv_r_reg <= {dv_r_reg[63:0], dv_n_reg[DVW-1]};
        dv_n_reg <= {dv_n_reg[DVW-2:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  always_ff @(posedge i_clk)
  begin
    if (acc)
    begin
      smp_mem[0][ii] <= i_smp.ch1;                        // [RL1]
      smp_mem[1][ii] <= i_smp.ch2;
    end
  end

  always_ff @(posedge i_clk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (st_reg == ST_LOAD)
        wk_mem[c][rev] <= ld[c];
      else if (st_reg == ST_FFT)
      begin
        wk_mem[c][itop] <= bhi[c];                        // [RL9]
        wk_mem[c][ibot] <= blo[c];
      end
    end
  end

  // Keep only speed-gate bins, filed by angle code [RL10]
  always_ff @(posedge i_clk)
  begin
    if (st_reg == ST_EMIT && push && pass_reg != 3'h0
        && ii >= 8'(BIN_LO) && ii <= 8'(BIN_HI))
    begin
      for (int c = 0; c < 2; c++)
        wd_mem[c][proc_reg[gsel]][4'(ii - 8'(BIN_LO))] <= wk_mem[c][ii];
    end
  end

  // Unity weights until loaded [RL16]
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int i = 0; i < NS; i++)
        wn_mem[i] <= W_ONE;
      for (int i = 0; i < NWS; i++)
        ww_mem[i] <= W_ONE;
    end
    else if (i_coef_we && !i_coef_wide)
      wn_mem[i_coef_addr] <= i_coef_data;
    else if (i_coef_we)
      ww_mem[i_coef_addr[5:0]] <= i_coef_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry skid buffer toward the receiver

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      out_v_reg <= 1'b0;
      sk_v_reg  <= 1'b0;
      out_reg   <= '0;
      sk_reg    <= '0;
    end
    else if (push)
    begin
      if (!out_v_reg || i_res_ready)
      begin
        out_reg   <= rec;
        out_v_reg <= 1'b1;
      end
      else
      begin
        sk_reg   <= rec;
        sk_v_reg <= 1'b1;
      end
    end
    else if (out_v_reg && i_res_ready)
    begin
      if (sk_v_reg)
      begin
        out_reg  <= sk_reg;
        sk_v_reg <= 1'b0;
      end
      else
        out_v_reg <= 1'b0;
    end
  end

  assign o_smp_ready = smp_rdy_reg;
  assign o_res_valid = out_v_reg;
  assign o_res       = out_reg;
  assign o_angle_seq = seq_reg;                           // [RL5]

endmodule : mddu_top
`default_nettype wire

// ===== sim/mddu_checker.sv
`timescale 1ns/10ps
`default_nettype none
module mddu_checker
  import mddu_pkg::*;
(
  input wire logic      i_clk,       // Clock
  input wire logic      i_rst_b,     // Reset
  input wire logic      i_smp_valid, // Offer
  input wire logic      o_smp_ready, // Accept
  input wire logic      i_res_ready, // Sink
  input wire logic      o_res_valid, // Valid
  input wire mddu_rec_s o_res        // Record
);
  logic [7:0] n_reg;
  wire logic  v = o_res_valid;
  wire mddu_rec_e k = o_res.kind;
  // Wraps at 256, so each period starts again at zero
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      n_reg <= 8'h00;
    else if (i_smp_valid && o_smp_ready)
      n_reg <= n_reg + 8'h01;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////////////////
  chk_last_take: assert property (
    i_smp_valid && o_smp_ready && n_reg == 8'hFF |=> !o_smp_ready)
    else $error("Ready high past last sample");
  chk_grp_slice: assert property (
    v && k == REC_SAMPLE |-> o_res.grp == o_res.idx[7:6])
    else $error("Sample group wrong");
  chk_hold_out: assert property (
    v && !i_res_ready |=> v && $stable(o_res))
    else $error("Record changed while stalled");
  chk_gate_bins: assert property (
    v && k >= REC_VEL |-> o_res.idx >= {3'h0, BIN_LO}
    && o_res.idx <= {3'h0, BIN_HI}) else $error("Bin outside gate");
  chk_vel_pair: assert property (
    v && k == REC_VEL |-> o_res.idx <= {3'h0, VEL_HI})
    else $error("Velocity bin too high");
  chk_ang_clamp: assert property (
    v && k inside {REC_DAZM, REC_DELV} |-> o_res.v1.re <= LIM_TWO
    && o_res.v1.re >= -LIM_TWO) else $error("Angle term not clamped");
  chk_wide_bins: assert property (
    v && k == REC_WIDE |-> o_res.idx[7:6] == 2'h0)
    else $error("Wide bin above 63");
  chk_sample_ext: assert property (
    v && k == REC_SAMPLE |-> o_res.v1.re[23:15] == 9'h000
    || &o_res.v1.re[23:15]) else $error("Sample not extended");
  cover property (v && i_res_ready && k == REC_VEL);
  cover property (v && !i_res_ready);
  cover property (i_smp_valid && o_smp_ready && n_reg == 8'hFF);
endmodule : mddu_checker
`default_nettype wire

// ===== sim/mddu_partner.sv
`timescale 1ns/10ps
`default_nettype none
module mddu_partner
  import mddu_pkg::*;
(
  input  wire logic i_clk,       // Clock
  input  wire logic i_rst_b,     // Reset
  input  wire logic i_smp_ready, // Pair taken
  output logic      o_smp_valid, // Pair offered
  output mddu_sin_s o_smp,       // Sample pair
  output logic      o_res_ready  // Sink ready
);
  logic [7:0] n_reg;
  logic [1:0] ph_reg;
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      n_reg <= 8'h00;
    else if (o_smp_valid && i_smp_ready)
      n_reg <= n_reg + 8'h01;
  initial
  begin
    ph_reg = 2'h0;
    o_smp_valid = 1'b1;
    o_smp = '0;
    o_res_ready = 1'b1;
  end
  // Ramp held until taken; sink stalls one cycle in four
  always @(negedge i_clk)
  begin
    ph_reg = ph_reg + 2'h1;
    o_res_ready = ph_reg != 2'h3;
    o_smp.ch1.re = {8'h00, n_reg} - 16'h0080;
    o_smp.ch1.im = {8'h00, n_reg};
    o_smp.ch2.re = 16'h0000 - {8'h00, n_reg};
    o_smp.ch2.im = 16'h0007;
  end
endmodule : mddu_partner
`default_nettype wire

// ===== sim/mddu_bench.sv
`timescale 1ns/10ps
`default_nettype none
module mddu_bench
  import mddu_pkg::*;
;
  localparam mddu_seq_t S1 = '{ANG_AZM_P, ANG_ELV_N, ANG_AZM_N, ANG_ELV_P};
  localparam mddu_seq_t S2 = '{ANG_AZM_N, ANG_AZM_P, ANG_ELV_P, ANG_ELV_N};
  logic              i_clk, i_rst_b, i_smp_valid, o_smp_ready;
  logic              i_seq_valid, i_coef_we, i_coef_wide;
  logic              i_res_ready, o_res_valid;
  mddu_sin_s         i_smp;
  mddu_seq_t         i_seq, o_angle_seq;
  logic [7:0]        i_coef_addr;
  logic signed [15:0] i_coef_data;
  mddu_rec_s         o_res;
  mddu_rec_s         rec_q[$];
  int                mismatches, n_tests;
  mddu_top dut (.i_clk, .i_rst_b, .i_smp_valid, .i_smp, .o_smp_ready,
    .i_seq_valid, .i_seq, .i_coef_we, .i_coef_wide, .i_coef_addr,
    .i_coef_data, .i_res_ready, .o_res_valid, .o_res, .o_angle_seq);
  mddu_partner peer (.i_clk, .i_rst_b, .i_smp_ready(o_smp_ready),
    .o_smp_valid(i_smp_valid), .o_smp(i_smp), .o_res_ready(i_res_ready));
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
    if (i_rst_b && o_res_valid && i_res_ready)
      rec_q.push_back(o_res);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : check
  task automatic conclude();
    $display("Counts: %0d mismatches, %0d tests", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // One period: 832 records in fixed order, then the new order stored
  task automatic run_period(input mddu_seq_t cur, input mddu_seq_t nxt);
    mddu_rec_s r;
    int w;
    int e;
    logic signed [31:0] d;
    check(o_angle_seq === cur, "order before");
    @(negedge i_clk);
    i_seq = nxt;
    i_seq_valid = 1'b1;
    @(negedge i_clk);
    i_seq_valid = 1'b0;
    w = 0;
    while (rec_q.size() < 832 && w < 40000)
    begin
      @(negedge i_clk);
      w++;
    end
    check(rec_q.size() >= 832, "records missing");
    if (rec_q.size() < 832)
      return;
    for (int n = 0; n < 832; n++)
    begin
      r = rec_q.pop_front();
      e = n < 768 ? n / 256 : n < 828 ? 3 + (n - 768) % 5 : n - 824;
      w = n < 512 ? n % 256 : n < 768 ? n % 64 : n < 828 ?
        12 + (n - 768) / 5 : 24;
      check(r.kind === 3'(e), "kind");
      check(r.idx === 8'(w), "index");
      if (e == 0 || e == 2)
        check(r.grp === n[7:6] && r.ang === cur[n[7:6]], "tag");
      if (e == 0)
        check(r.v1.re === 24'(n - 128) && r.v2.re === 24'(-n), "smp");
      // Only kept weights count: ch1.im bin 0 is the ramp summed over them
      d = n == 256 ? r.v1.im - 8128 : r.v1.im - 2048 * (n / 64 - 8) - 496;
      if (n == 256 || (e == 2 && w == 0))
        check(d < 512 && d > -512, "bin 0");
    end
    check(o_angle_seq === nxt, "order after");
  endtask : run_period
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    i_rst_b = 1'b0;
    i_seq_valid = 1'b0;
    i_seq = SEQ_RST;
    i_coef_we = 1'b0;
    i_coef_wide = 1'b0;
    i_coef_addr = 8'h00;
    i_coef_data = 16'sh0000;
    repeat (2) @(negedge i_clk);
    i_rst_b = 1'b1;
    // Zero wide weights 32..63 and narrow weights 128..255
    i_coef_we = 1'b1;
    for (int i = 32; i < 192; i++)
    begin
      i_coef_wide = i < 64;
      i_coef_addr = 8'(i < 64 ? i : i + 64);
      @(negedge i_clk);
    end
    i_coef_we = 1'b0;
    run_period(SEQ_RST, S1);
    run_period(S1, S2);
    conclude();
  end
  initial
  begin
    #360000;
    mismatches++;
    conclude();
  end
endmodule : mddu_bench
bind mddu_top mddu_checker chk (.i_clk, .i_rst_b, .i_smp_valid,
  .o_smp_ready, .i_res_ready, .o_res_valid, .o_res);
`default_nettype wire
